// ### hw/byte_generator.sv
`include "pkt_gen_map.svh"
`default_nettype none
module byte_generator
  import pkt_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire gen_cfg_s cfg_i,
  input wire logic start_i,
  input wire logic stop_i,
  // Byte stream
  output logic [7:0] data_o,
  output logic valid_o,
  output logic last_o,
  input wire logic ready_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  gen_state_e state_reg, state_next;
  logic [7:0] idx_reg, idx_next;
  logic [7:0] incr_reg, incr_next;
  logic [15:0] lfsr_reg, lfsr_next;
  logic [19:0] sent_reg, sent_next;
  logic [19:0] target_reg, target_next;
  logic [7:0] data_reg, data_next;
  logic done_reg, done_next;
  logic [2:0] vld;

  function automatic logic [19:0] decade(input logic [2:0] code);
    case (code)
      3'h0: decade = 20'h00001;
      3'h1: decade = 20'h0000A;
      3'h2: decade = 20'h00064;
      3'h3: decade = 20'h003E8;
      3'h4: decade = 20'h02710;
      3'h5: decade = 20'h186A0;
      default: decade = 20'hF4240;
    endcase
  endfunction : decade

  function automatic logic [7:0] pick(input logic [7:0] i,
                                      input logic [7:0] inc,
                                      input logic [15:0] lf);
    if (i < {5'h00, vld}) begin
      pick = cfg_i.pattern[{i[2:0], 3'h0} +: 8];
    end else if (cfg_i.ctrl.mode[1]) begin // R5
      pick = lf[7:0];
    end else if (cfg_i.ctrl.mode[0]) begin
      pick = cfg_i.ctrl.fixed_byte; // R4
    end else begin
      pick = inc;
    end
  endfunction : pick

  assign vld = (cfg_i.ctrl.vld_bytes == 3'h7) ? 3'h6 : cfg_i.ctrl.vld_bytes; // R6

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    incr_next = incr_reg;
    lfsr_next = lfsr_reg;
    sent_next = sent_reg;
    target_next = target_reg;
    done_next = 1'b0;
    case (state_reg)
      GEN_IDLE: begin
        if (start_i) begin
          state_next = GEN_SEND;
          idx_next = 8'h00;
          sent_next = 20'h00000;
          target_next = decade(cfg_i.ctrl.pkt_cnt); // R7
        end
      end
      GEN_SEND: begin
        if (ready_i) begin
          idx_next = idx_reg + 8'h01;
          if (idx_reg >= {5'h00, vld}) begin
            incr_next = incr_reg + 8'h01; // R16
            lfsr_next = {lfsr_reg[14:0],
              lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
          end
          if (idx_reg == `GEN_PKT_LEN - 8'h01) begin
            sent_next = sent_reg + 20'h00001;
            idx_next = 8'h00;
            state_next = GEN_GAP;
          end
        end
      end
      GEN_GAP: begin
        idx_next = idx_reg + 8'h01;
        if (idx_reg == `GEN_GAP_LEN - 8'h01) begin
          idx_next = 8'h00;
          if (cfg_i.ctrl.pkt_cnt != 3'h7 && sent_reg == target_reg) begin
            state_next = GEN_IDLE; // R16
            done_next = 1'b1;
          end else begin
            state_next = GEN_SEND;
          end
        end
      end
      default: state_next = GEN_IDLE;
    endcase
    if (stop_i && state_reg != GEN_IDLE) begin
      state_next = GEN_IDLE;
      done_next = 1'b1;
    end
    data_next = pick(idx_next, incr_next, lfsr_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= GEN_IDLE;
      idx_reg <= 8'h00;
      incr_reg <= 8'h00;
      lfsr_reg <= `GEN_LFSR_SEED;
      sent_reg <= 20'h00000;
      target_reg <= 20'h00000;
      data_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      incr_reg <= incr_next;
      lfsr_reg <= lfsr_next;
      sent_reg <= sent_next;
      target_reg <= target_next;
      data_reg <= data_next;
      done_reg <= done_next;
    end
  end

  assign data_o = data_reg;
  assign valid_o = (state_reg == GEN_SEND);
  assign last_o = valid_o && (idx_reg == `GEN_PKT_LEN - 8'h01);
  assign busy_o = (state_reg != GEN_IDLE);
  assign done_o = done_reg;
endmodule : byte_generator
`default_nettype wire

// ### hw/mac_packet_generator_checker.sv
`include "pkt_gen_map.svh"
`default_nettype none
module mac_packet_generator_checker
  import pkt_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Datapath events, one-cycle pulses
  input wire dp_evt_s evt_i,
  // Checker view of the configuration
  output logic [47:0] dest_match_o,
  // Generated byte stream
  output logic [7:0] gen_data_o,
  output logic gen_valid_o,
  output logic gen_last_o,
  input wire logic gen_ready_i,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req, wr, rd;
  logic lo_wr;
  logic [15:0] wdata;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  assign req = cyc_i && stb_i && !ack_reg;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  assign lo_wr = wr && sel_i[0] && sel_i[1];
  assign wdata = dat_i[15:0];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  gen_cfg_s cfg_reg, cfg_next;
  logic [47:0] da_reg, da_next;
  logic mode_reg, mode_next;
  logic start, stop;
  logic gen_busy, gen_done;

  always_comb begin
    cfg_next = cfg_reg;
    da_next = da_reg;
    mode_next = mode_reg;
    if (lo_wr) begin
      if (adr_i == `GEN_CTRL_IDX) begin
        cfg_next.ctrl = gen_ctrl_s'(wdata); // R4 R5 R6 R7
      end else if (adr_i == `PAT_LO_IDX) begin
        cfg_next.pattern[15:0] = wdata; // R8
      end else if (adr_i == `PAT_MID_IDX) begin
        cfg_next.pattern[31:16] = wdata; // R8
      end else if (adr_i == `PAT_HI_IDX) begin
        cfg_next.pattern[47:32] = wdata; // R8
      end else if (adr_i == `DA_LO_IDX) begin
        da_next[15:0] = wdata; // R9
      end else if (adr_i == `DA_MID_IDX) begin
        da_next[31:16] = wdata; // R9
      end else if (adr_i == `DA_HI_IDX) begin
        da_next[47:32] = wdata; // R9
      end else if (adr_i == `CHK_CTRL_IDX) begin
        mode_next = wdata[`CHK_MODE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= {`GEN_CTRL_RST, 48'h000000000000};
      da_reg <= 48'h000000000000;
      mode_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      da_reg <= da_next;
      mode_reg <= mode_next;
    end
  end

  logic chk_wr;
  assign chk_wr = lo_wr && (adr_i == `CHK_CTRL_IDX);
  assign start = chk_wr && wdata[`GEN_START_BIT];
  assign stop = chk_wr && wdata[`GEN_STOP_BIT];
  assign dest_match_o = da_reg; // R9

  byte_generator gen_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(cfg_reg),
    .start_i(start),
    .stop_i(stop),
    .data_o(gen_data_o),
    .valid_o(gen_valid_o),
    .last_o(gen_last_o),
    .ready_i(gen_ready_i),
    .busy_o(gen_busy),
    .done_o(gen_done)
  );

  // ----------------------------------------------------------------
  // Errored-packet counter
  // ----------------------------------------------------------------
  logic lock, lock_clr;
  logic [31:0] err_reg, err_next;
  logic [31:0] snap_reg, snap_next;
  logic ov_reg, ov_next;

  assign lock = chk_wr && wdata[`CHK_LOCK_BIT]; // R13
  assign lock_clr = chk_wr && wdata[`CHK_CLEAR_BIT]; // R13

  always_comb begin
    err_next = err_reg;
    ov_next = ov_reg;
    snap_next = snap_reg;
    if (lock || lock_clr) begin
      snap_next = err_reg; // R2
    end
    if (lock_clr) begin
      err_next = 32'h00000000; // R13
      ov_next = 1'b0;
    end
    if (evt_i.pkt_err) begin // R1
      if (lock_clr) begin
        err_next = 32'h00000001;
      end else if (err_reg == 32'hFFFFFFFF) begin
        ov_next = 1'b1;
        if (mode_reg) begin
          err_next = 32'h00000000;
        end // R3
      end else begin
        err_next = err_reg + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg <= 32'h00000000;
      snap_reg <= 32'h00000000;
      ov_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
      snap_reg <= snap_next;
      ov_reg <= ov_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame check flags, cleared by read
  // ----------------------------------------------------------------
  logic [1:0] crc_reg, crc_next;
  logic crc_rd;
  assign crc_rd = rd && (adr_i == `CRC_STAT_IDX);

  always_comb begin
    crc_next = crc_rd ? 2'h0 : crc_reg;
    if (evt_i.rx_crc) begin
      crc_next[1] = 1'b1; // R10
    end
    if (evt_i.tx_crc) begin
      crc_next[0] = 1'b1; // R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_reg <= 2'h0;
    end else begin
      crc_reg <= crc_next;
    end
  end

  // ----------------------------------------------------------------
  // Transmit statistics
  // ----------------------------------------------------------------
  logic [31:0] txp_reg, txp_next;
  logic [15:0] txe_reg, txe_next;
  logic [1:0] seq_reg, seq_next;

  always_comb begin
    txp_next = txp_reg;
    txe_next = txe_reg;
    seq_next = seq_reg;
    if (rd) begin
      if (adr_i == `TX_LO_IDX) begin
        seq_next = 2'h1;
      end else if (adr_i == `TX_HI_IDX && seq_reg == 2'h1) begin
        seq_next = 2'h2;
      end else if (adr_i == `TX_ERR_IDX && seq_reg == 2'h2) begin
        seq_next = 2'h0;
        txp_next = 32'h00000000; // R15
        txe_next = 16'h0000;
      end else begin
        seq_next = 2'h0;
      end
    end
    if (evt_i.tx_pkt) begin
      txp_next = txp_next + 32'h00000001;
    end
    if (evt_i.tx_crc) begin
      txe_next = txe_next + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txp_reg <= 32'h00000000;
      txe_reg <= 16'h0000;
      seq_reg <= 2'h0;
    end else begin
      txp_reg <= txp_next;
      txe_reg <= txe_next;
      seq_reg <= seq_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [`IRQ_W-1:0] ist_reg, ist_next;
  logic [`IRQ_W-1:0] ien_reg, ien_next;
  logic [`IRQ_W-1:0] evt_vec;

  assign evt_vec = {gen_done, evt_i.tx_crc, evt_i.rx_crc, evt_i.pkt_err};

  always_comb begin
    ist_next = ist_reg;
    ien_next = ien_reg;
    if (lo_wr && adr_i == `IRQ_CLR_IDX) begin
      ist_next = ist_reg & ~wdata[`IRQ_W-1:0];
    end
    if (lo_wr && adr_i == `IRQ_EN_IDX) begin
      ien_next = wdata[`IRQ_W-1:0];
    end
    ist_next = ist_next | evt_vec;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_reg <= '0;
      ien_reg <= '0;
    end else begin
      ist_reg <= ist_next;
      ien_reg <= ien_next;
    end
  end

  assign irq_o = |(ist_reg & ien_reg);

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  logic [15:0] rd_val;

  always_comb begin
    rd_val = 16'h0000;
    if (adr_i == `ERR_LO_IDX) begin
      rd_val = snap_reg[15:0]; // R1 R2
    end else if (adr_i == `ERR_HI_IDX) begin
      rd_val = snap_reg[31:16]; // R1 R2
    end else if (adr_i == `GEN_CTRL_IDX) begin
      rd_val = cfg_reg.ctrl;
    end else if (adr_i == `PAT_LO_IDX) begin
      rd_val = cfg_reg.pattern[15:0];
    end else if (adr_i == `PAT_MID_IDX) begin
      rd_val = cfg_reg.pattern[31:16];
    end else if (adr_i == `PAT_HI_IDX) begin
      rd_val = cfg_reg.pattern[47:32];
    end else if (adr_i == `DA_LO_IDX) begin
      rd_val = da_reg[15:0];
    end else if (adr_i == `DA_MID_IDX) begin
      rd_val = da_reg[31:16];
    end else if (adr_i == `DA_HI_IDX) begin
      rd_val = da_reg[47:32];
    end else if (adr_i == `CRC_STAT_IDX) begin
      rd_val = {14'h0000, crc_reg}; // R12
    end else if (adr_i == `TX_LO_IDX) begin
      rd_val = txp_reg[15:0]; // R14
    end else if (adr_i == `TX_HI_IDX) begin
      rd_val = txp_reg[31:16];
    end else if (adr_i == `TX_ERR_IDX) begin
      rd_val = txe_reg;
    end else if (adr_i == `CHK_CTRL_IDX) begin
      rd_val[`CHK_MODE_BIT] = mode_reg;
      rd_val[`CHK_OV_BIT] = ov_reg;
      rd_val[`GEN_BUSY_BIT] = gen_busy;
      rd_val[`GEN_DONE_BIT] = ist_reg[`IRQ_GEN_DONE];
    end else if (adr_i == `IRQ_STAT_IDX) begin
      rd_val[`IRQ_W-1:0] = ist_reg;
    end else if (adr_i == `IRQ_EN_IDX) begin
      rd_val[`IRQ_W-1:0] = ien_reg;
    end
  end

  always_comb begin
    ack_next = req;
    rdata_next = rdata_reg;
    if (rd) begin
      rdata_next = {16'h0000, rd_val};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;
endmodule : mac_packet_generator_checker
`default_nettype wire

// ### hw/pkt_gen_map.svh
// Summary of operation
// (R1) Errored-packet count is 32 bits, read as low and high 16-bit words.
// (R2) Writing lock or lock-and-clear bit freezes the readable error count.
// (R3) With count mode zero the error counter saturates at all ones.
// (R4) Control bits 15:8, reset 0x55, give the fixed payload byte.
// (R5) Bits 7:6 pick payload: 00 incrementing, 01 fixed, 1x pseudo-random.
// (R6) Bits 5:3, reset 2, give valid pattern bytes; code 7 means six.
// (R7) Bits 2:0, reset 1, give ten-power packet count; code 7 continuous.
// (R8) 48-bit pattern, reset zero, in three words, least significant first.
// (R9) 48-bit exact-match value, reset zero, compared with destination address.
// (R10) Bit 1 of frame check status flags a receive CRC error.
// (R11) Bit 0 of frame check status flags a transmit CRC error.
// (R12) Frame check status bits 15:2 read zero and ignore writes.
// (R13) Lock bit freezes counters; lock-and-clear also clears them and overflow.
// (R14) First statistics register returns low half of transmit packet count.
// (R15) Reading low, high, errored statistics in order clears them.
// (R16) Incrementing payload adds one per byte; generation stops after count.
`ifndef PKT_GEN_MAP_SVH
`define PKT_GEN_MAP_SVH
// Register indices; byte address is four times the index
`define ERR_LO_IDX 12'h622
`define ERR_HI_IDX 12'h623
`define GEN_CTRL_IDX 12'h624
`define PAT_LO_IDX 12'h625
`define PAT_MID_IDX 12'h626
`define PAT_HI_IDX 12'h627
`define DA_LO_IDX 12'h628
`define DA_MID_IDX 12'h629
`define DA_HI_IDX 12'h62A
`define CRC_STAT_IDX 12'h638
`define TX_LO_IDX 12'h639
`define TX_HI_IDX 12'h63A
`define TX_ERR_IDX 12'h63B
`define CHK_CTRL_IDX 12'h640
`define IRQ_STAT_IDX 12'h641
`define IRQ_CLR_IDX 12'h642
`define IRQ_EN_IDX 12'h643
// Reset values
`define GEN_CTRL_RST 16'h5511
// Checker control fields
`define CHK_LOCK_BIT 0
`define CHK_CLEAR_BIT 1
`define CHK_MODE_BIT 2
`define GEN_START_BIT 3
`define GEN_STOP_BIT 4
`define CHK_OV_BIT 8
`define GEN_BUSY_BIT 9
`define GEN_DONE_BIT 10
// Interrupt bit positions
`define IRQ_PKT_ERR 0
`define IRQ_RX_CRC 1
`define IRQ_TX_CRC 2
`define IRQ_GEN_DONE 3
`define IRQ_W 4
// Generator timing
`define GEN_PKT_LEN 8'd64
`define GEN_GAP_LEN 8'd12
`define GEN_LFSR_SEED 16'hACE1
`endif

// ### hw/pkt_gen_pkg.sv
`default_nettype none
package pkt_gen_pkg;
  typedef struct packed {
    logic [7:0] fixed_byte;
    logic [1:0] mode;
    logic [2:0] vld_bytes;
    logic [2:0] pkt_cnt;
  } gen_ctrl_s;

  typedef struct packed {
    gen_ctrl_s ctrl;
    logic [47:0] pattern;
  } gen_cfg_s;

  typedef struct packed {
    logic tx_pkt;
    logic tx_crc;
    logic rx_crc;
    logic pkt_err;
  } dp_evt_s;

  typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP} gen_state_e;
endpackage : pkt_gen_pkg
`default_nettype wire

// ### testbench/mac_partner_model.sv
`default_nettype none
module mac_partner_model
  import pkt_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic slow_i,
  input wire dp_evt_s req_i,
  // Generated stream
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  input wire logic last_i,
  output logic ready_o,
  // Datapath events
  output dp_evt_s evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      evt_o <= '0;
    end else begin
      ready_o <= !slow_i || ($urandom_range(2) == 0);
      evt_o <= dp_evt_s'(req_i | {valid_i && ready_o && last_i, 3'h0});
      if (valid_i && ready_o) begin
        rx_q.push_back(data_i);
      end
    end
  end
endmodule : mac_partner_model
`default_nettype wire

// ### testbench/mac_pgc_chk.sv
`include "pkt_gen_map.svh"
`default_nettype none
module mac_pgc_chk
  import pkt_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Datapath and stream
  input wire dp_evt_s evt_i,
  input wire logic [47:0] dest_match_o,
  input wire logic [7:0] gen_data_o,
  input wire logic gen_valid_o,
  input wire logic gen_last_o,
  input wire logic gen_ready_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take, rd_crc, wr_dl, rx_p, tx_p;
  logic [15:0] dl_q;
  logic [6:0] beat;
  assign take = cyc_i && stb_i && !ack_o;
  assign rd_crc = take && !we_i && adr_i == `CRC_STAT_IDX;
  assign wr_dl = take && we_i && sel_i[1:0] == 2'b11 && adr_i == `DA_LO_IDX;
  // Sticky flags and beat count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_p <= 1'b0;
      tx_p <= 1'b0;
      dl_q <= 16'h0000;
      beat <= 7'h00;
    end else begin
      rx_p <= evt_i.rx_crc || (rx_p && !rd_crc);
      tx_p <= evt_i.tx_crc || (tx_p && !rd_crc);
      if (wr_dl) dl_q <= dat_i[15:0];
      if (gen_valid_o && gen_ready_i) beat <= gen_last_o ? 7'h00 : beat + 7'h01;
      else if (!gen_valid_o) beat <= 7'h00;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_once: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse per request");
  a_hi_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_crc_zero: assert property (rd_crc |=> dat_o[31:2] == 30'h0)
    else $error("reserved status bits not zero");
  a_rx_flag: assert property (rd_crc |=> dat_o[1] == $past(rx_p))
    else $error("receive check flag wrong");
  a_tx_flag: assert property (rd_crc |=> dat_o[0] == $past(tx_p))
    else $error("transmit check flag wrong");
  a_dest_lo: assert property (wr_dl |=> ##[0:1] dest_match_o[15:0] == dl_q)
    else $error("match value not applied");
  a_gen_hold: assert property (gen_valid_o && !gen_ready_i |=> gen_valid_o
    && $stable(gen_data_o) && $stable(gen_last_o))
    else $error("stalled byte not held");
  a_pkt_len: assert property (gen_valid_o && gen_ready_i |->
    gen_last_o == (beat == 7'h3F))
    else $error("packet length wrong");
  a_pkt_gap: assert property (gen_valid_o && gen_ready_i && gen_last_o
    |=> !gen_valid_o [*8])
    else $error("gap after packet too short");
  c_crc_read: cover property (rd_crc);
  c_pkt_end: cover property (gen_valid_o && gen_ready_i && gen_last_o);
  c_irq_up: cover property ($rose(irq_o));
endmodule : mac_pgc_chk
bind mac_packet_generator_checker mac_pgc_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .evt_i(evt_i), .dest_match_o(dest_match_o), .gen_data_o(gen_data_o),
  .gen_valid_o(gen_valid_o), .gen_last_o(gen_last_o),
  .gen_ready_i(gen_ready_i), .irq_o(irq_o));
`default_nettype wire

// ### testbench/tb_top.sv
`include "pkt_gen_map.svh"
`default_nettype none
module tb_top
  import pkt_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic slow = 1'b0, ack_o, gv, gl, gr, irq_o;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [7:0] gd;
  logic [47:0] dm, pat;
  logic [15:0] q;
  dp_evt_s req = '0, evt;
  int num_errors = 0, num_checks = 0, cyc_n = 0, n;
  int shadow[int];
  always #2.5 clk_i = ~clk_i;
  mac_packet_generator_checker dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .evt_i(evt),
    .dest_match_o(dm), .gen_data_o(gd), .gen_valid_o(gv),
    .gen_last_o(gl), .gen_ready_i(gr), .irq_o(irq_o));
  mac_partner_model pm_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .req_i(req), .data_i(gd), .valid_i(gv), .last_i(gl), .ready_o(gr),
    .evt_o(evt));
  // --------
  // Tasks
  // --------
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [47:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 4'hF);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic ev(input logic [3:0] e, input int k);
    repeat (k) begin
      @(posedge clk_i);
      req <= dp_evt_s'(e);
    end
    @(posedge clk_i);
    req <= '0;
    repeat (3) @(posedge clk_i);
  endtask : ev
  task automatic pkts(input logic [15:0] c, input int np);
    pm_u.rx_q.delete();
    wr(`GEN_CTRL_IDX, c);
    wr(`CHK_CTRL_IDX, 16'h0008);
    while (pm_u.rx_q.size() < 64 * np) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    chk("byte count", 64 * np, pm_u.rx_q.size());
  endtask : pkts
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", e, irq_o);
  endtask : irq_is
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  // --------
  // Sequence
  // --------
  initial begin
    n = $urandom(32'h9DC9);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd(12'(16'h0622 + i), i == 2 ? 16'h5511 : 16'h0000);
    rd(`CRC_STAT_IDX, 16'h0000);
    rd(`TX_LO_IDX, 16'h0000);
    chk("dest", 48'h0, dm);
    for (int i = 2; i < 9; i++) begin
      shadow[i] = $urandom;
      wr(12'(16'h0622 + i), 16'(shadow[i]));
    end
    bus(1'b1, `GEN_CTRL_IDX, 16'h0000, 4'h1);
    for (int i = 2; i < 9; i++)
      rd(12'(16'h0622 + i), 16'(shadow[i]));
    chk("dest", {16'(shadow[8]), 16'(shadow[7]), 16'(shadow[6])}, dm);
    wr(`ERR_LO_IDX, 16'hFFFF);
    rd(`ERR_LO_IDX, 16'h0000);
    wr(`CRC_STAT_IDX, 16'hFFFF);
    rd(`CRC_STAT_IDX, 16'h0000);
    wr(12'h7FF, 16'h1234);
    rd(12'h7FF, 16'h0000);
    pat = 48'({$urandom, $urandom});
    for (int i = 0; i < 3; i++)
      wr(12'(16'h0625 + i), pat[16*i +: 16]);
    pkts(16'hA500, 1);
    for (int i = 0; i < 64; i++)
      chk("inc byte", 8'(i), pm_u.rx_q[i]);
    slow <= 1'b1;
    pkts(16'h3C79, 10);
    for (int i = 0; i < 640; i++)
      chk("fixed byte", i % 64 < 6 ? pat[8*(i%64) +: 8] : 8'h3C,
        pm_u.rx_q[i]);
    rd(`TX_LO_IDX, 16'h000B);
    rd(`TX_HI_IDX, 16'h0000);
    rd(`TX_ERR_IDX, 16'h0000);
    rd(`TX_LO_IDX, 16'h0000);
    rd(`IRQ_STAT_IDX, 16'h0008);
    for (int m = 2; m < 4; m++) begin
      pkts(m == 2 ? 16'h0090 : 16'h00D0, 1);
      chk("prbs lead", pat[15:0], {pm_u.rx_q[1], pm_u.rx_q[0]});
    end
    wr(`IRQ_CLR_IDX, 16'h000F);
    wr(`CHK_CTRL_IDX, 16'h0004);
    rd(`CHK_CTRL_IDX, 16'h0004);
    n = $urandom_range(9, 3);
    ev(4'h1, n);
    rd(`ERR_LO_IDX, 16'h0000);
    wr(`CHK_CTRL_IDX, 16'h0001);
    rd(`ERR_LO_IDX, 16'(n));
    rd(`ERR_HI_IDX, 16'h0000);
    ev(4'h1, 2);
    rd(`ERR_LO_IDX, 16'(n));
    wr(`CHK_CTRL_IDX, 16'h0002);
    rd(`ERR_LO_IDX, 16'(n + 2));
    wr(`CHK_CTRL_IDX, 16'h0001);
    rd(`ERR_LO_IDX, 16'h0000);
    ev(4'h2, 1);
    rd(`CRC_STAT_IDX, 16'h0002);
    rd(`CRC_STAT_IDX, 16'h0000);
    ev(4'h4, 1);
    rd(`CRC_STAT_IDX, 16'h0001);
    rd(`TX_ERR_IDX, 16'h0001);
    wr(`IRQ_CLR_IDX, 16'h000F);
    wr(`IRQ_EN_IDX, 16'h0001);
    ev(4'h1, 1);
    irq_is(1'b1);
    wr(`IRQ_EN_IDX, 16'h0000);
    irq_is(1'b0);
    wr(`IRQ_EN_IDX, 16'h0001);
    irq_is(1'b1);
    wr(`IRQ_CLR_IDX, 16'h0001);
    irq_is(1'b0);
    rd(`IRQ_STAT_IDX, 16'h0000);
    slow <= 1'b0;
    pm_u.rx_q.delete();
    wr(`GEN_CTRL_IDX, 16'h0007);
    wr(`CHK_CTRL_IDX, 16'h0008);
    while (pm_u.rx_q.size() < 64 * 12) @(posedge clk_i);
    wr(`CHK_CTRL_IDX, 16'h0010);
    repeat (100) @(posedge clk_i);
    n = pm_u.rx_q.size();
    repeat (200) @(posedge clk_i);
    chk("after stop", n, pm_u.rx_q.size());
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
